// [src/cpw_defines.svh]
`ifndef CPW_DEFINES_SVH
`define CPW_DEFINES_SVH

// Register byte addresses
`define CPW_ADDR_PERIOD 4'h0
`define CPW_ADDR_DUTY_WR 4'h4
`define CPW_ADDR_SHADOW 4'h8
`define CPW_ADDR_CTRL 4'hc
`define CPW_ADDR_MISC 5'h10
`define CPW_ADDR_COUNT 5'h14

// Control register fields
`define CPW_CTRL_DUTY_LSB_HI 5
`define CPW_CTRL_DUTY_LSB_LO 4
`define CPW_CTRL_MODE_HI 3
`define CPW_CTRL_MODE_LO 0
`define CPW_CTRL_MASK 8'h3f
`define CPW_PWM_MODE_MASK 4'hc

// Prescale select and run fields in the misc register
`define CPW_MISC_PRE_HI 1
`define CPW_MISC_PRE_LO 0
`define CPW_MISC_RUN 2

// Reset values
`define CPW_RST_PERIOD 8'hff
`define CPW_RST_BYTE 8'h00

// AXI responses
`define CPW_RESP_OKAY 2'b00
`define CPW_RESP_SLVERR 2'b10

`endif

// [src/cpw_pkg.sv]
package cpw_pkg;
  typedef enum logic [1:0] {
    CPW_PRE_1 = 2'b00,
    CPW_PRE_4 = 2'b01,
    CPW_PRE_16 = 2'b10,
    CPW_PRE_16B = 2'b11
  } cpw_pre_t;
  typedef logic [7:0] cpw_byte_t;
  typedef logic [9:0] cpw_duty_t;
endpackage

// [src/cpw_prescale.sv]
`timescale 1ns/100ps
`include "cpw_defines.svh"

module cpw_prescale (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic run,
  input wire logic clear,
  input wire cpw_pkg::cpw_pre_t pre_sel,
  // Outputs
  output logic tick,
  output logic [1:0] sub_count
);
  import cpw_pkg::*;

  logic [3:0] pre_cnt;
  logic [3:0] pre_last;
  logic wrap;

  assign pre_last = (pre_sel == CPW_PRE_1) ? 4'h0 :
                    (pre_sel == CPW_PRE_4) ? 4'h3 : 4'hf;
  assign wrap = (pre_cnt == pre_last);
  assign tick = run & wrap;
  // Two sub-cycle bits extend the timer: quarter ticks at 1:1 is not
  // available with one clock, so the two top prescale bits are used.
  assign sub_count = (pre_sel == CPW_PRE_1) ? 2'b00 :
                     (pre_sel == CPW_PRE_4) ? pre_cnt[1:0] : pre_cnt[3:2];

  always_ff @(posedge aclk) begin
    if (!aresetn || clear || !run || wrap) begin
      pre_cnt <= 4'h0;
    end else begin
      pre_cnt <= pre_cnt + 4'h1;
    end
  end
endmodule // cpw_prescale

// [src/cpw_axil.sv]
`timescale 1ns/100ps
`include "cpw_defines.svh"

module cpw_axil (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write address and data
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // Write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Register side
  output logic wr_en,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data,
  output logic [4:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_ok,
  input wire logic wr_ok
);
  logic aw_held;
  logic w_held;
  logic [4:0] aw_q;
  logic [7:0] w_q;
  logic w_lane;
  logic do_write;
  logic do_read;
  logic aw_take;
  logic w_take;
  logic next_aw_held;
  logic next_w_held;
  logic next_bvalid;
  logic next_rvalid;

  // Readies come from next state so every bus output leaves a flop
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign next_aw_held = !do_write && (aw_held || aw_take);
  assign next_w_held = !do_write && (w_held || w_take);
  assign next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
  assign wr_en = do_write && w_lane;
  assign wr_addr = aw_q;
  assign wr_data = w_q;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign next_rvalid = do_read || (s_axi_rvalid && !s_axi_rready);
  assign rd_addr = s_axi_araddr;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 5'h00;
      w_q <= 8'h00;
      w_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CPW_RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      s_axi_bvalid <= next_bvalid;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready <= !next_w_held && !next_bvalid;
      if (aw_take) begin
        aw_q <= s_axi_awaddr;
      end
      if (w_take) begin
        w_q <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end
      if (do_write) begin
        s_axi_bresp <= wr_ok ? `CPW_RESP_OKAY : `CPW_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CPW_RESP_OKAY;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_arready <= !next_rvalid;
      if (do_read) begin
        s_axi_rdata <= {24'h00_0000, rd_data};
        s_axi_rresp <= rd_ok ? `CPW_RESP_OKAY : `CPW_RESP_SLVERR;
      end
    end
  end
endmodule // cpw_axil

// [src/cpw_pwm.sv]
`timescale 1ns/100ps
`include "cpw_defines.svh"

module cpw_pwm (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Waveform
  output logic wave_output_pin
);
  import cpw_pkg::*;

  cpw_byte_t period_limit_reg;
  cpw_byte_t period_timer_count;
  cpw_byte_t duty_write_byte;
  cpw_byte_t duty_shadow_byte;
  logic [5:0] unit_control_reg;
  logic [1:0] duty_lsb_latch;
  logic [2:0] misc_reg;
  logic wave_latch;

  logic wr_en;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic rd_ok;
  logic wr_ok;

  logic tick;
  logic [1:0] sub_count;
  logic pwm_mode;
  logic timer_run;
  logic rollover;
  logic rollover_q;
  logic duty_zero;
  cpw_duty_t duty_next;
  cpw_duty_t shadow_full;
  cpw_duty_t timer_full;
  logic duty_match;
  logic wr_period;
  logic wr_duty;
  logic wr_shadow;
  logic wr_ctrl;
  logic wr_misc;
  logic wr_timer;
  logic ctrl_off;
  logic next_wave;
  logic [7:0] ctrl_read;

  // Bus slave answers in one cycle after both write halves are held
  cpw_axil u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok),
    .wr_ok(wr_ok)
  );

  cpw_prescale u_pre (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(timer_run),
    .clear(wr_timer),
    .pre_sel(cpw_pre_t'(misc_reg[`CPW_MISC_PRE_HI:`CPW_MISC_PRE_LO])),
    .tick(tick),
    .sub_count(sub_count)
  );

  // Register decode
  assign wr_period = wr_en && (wr_addr == {1'b0, `CPW_ADDR_PERIOD});
  assign wr_duty = wr_en && (wr_addr == {1'b0, `CPW_ADDR_DUTY_WR});
  assign wr_shadow = wr_en && (wr_addr == {1'b0, `CPW_ADDR_SHADOW});
  assign wr_ctrl = wr_en && (wr_addr == {1'b0, `CPW_ADDR_CTRL});
  assign wr_misc = wr_en && (wr_addr == `CPW_ADDR_MISC);
  assign wr_timer = wr_en && (wr_addr == `CPW_ADDR_COUNT);
  assign wr_ok = (wr_addr[1:0] == 2'b00) && (wr_addr <= `CPW_ADDR_COUNT);
  assign rd_ok = (rd_addr[1:0] == 2'b00) && (rd_addr <= `CPW_ADDR_COUNT);
  assign ctrl_off = wr_ctrl && (wr_data == 8'h00);

  assign ctrl_read = {2'b00, unit_control_reg};
  assign rd_data =
    (rd_addr == {1'b0, `CPW_ADDR_PERIOD}) ? period_limit_reg :
    (rd_addr == {1'b0, `CPW_ADDR_DUTY_WR}) ? duty_write_byte :
    (rd_addr == {1'b0, `CPW_ADDR_SHADOW}) ? duty_shadow_byte :
    (rd_addr == {1'b0, `CPW_ADDR_CTRL}) ? ctrl_read :
    (rd_addr == `CPW_ADDR_MISC) ? {5'h00, misc_reg} :
    (rd_addr == `CPW_ADDR_COUNT) ? period_timer_count : 8'h00;

  // Modes 11xx select PWM
  assign pwm_mode = ((unit_control_reg[`CPW_CTRL_MODE_HI:`CPW_CTRL_MODE_LO]
                     & `CPW_PWM_MODE_MASK) == `CPW_PWM_MODE_MASK);
  assign timer_run = misc_reg[`CPW_MISC_RUN];

  // Rollover occurs on the increment after equality
  assign rollover = tick && (period_timer_count == period_limit_reg);

  // 10-bit duty built from write byte and control bits 5:4
  assign duty_next = {duty_write_byte,
    unit_control_reg[`CPW_CTRL_DUTY_LSB_HI:`CPW_CTRL_DUTY_LSB_LO]};
  assign duty_zero = (shadow_full == 10'h000);
  assign shadow_full = {duty_shadow_byte, duty_lsb_latch};
  assign timer_full = {period_timer_count, sub_count};
  // Exact match only, so a duty past the period never clears
  assign duty_match = (shadow_full == timer_full);

  // Set lags rollover one clock, as clear lags its match, so the high
  // time is exactly the duty count; the pin trails the timer by a clock
  always_comb begin
    next_wave = wave_latch;
    if (!pwm_mode) begin
      next_wave = 1'b0;
    end else if (rollover_q) begin
      next_wave = !duty_zero;
    end else if (duty_match) begin
      next_wave = 1'b0;
    end
  end

  // Period limit and timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      period_limit_reg <= `CPW_RST_PERIOD;
      period_timer_count <= `CPW_RST_BYTE;
      rollover_q <= 1'b0;
    end else begin
      rollover_q <= rollover;
      if (wr_period) begin
        period_limit_reg <= wr_data;
      end
      if (wr_timer) begin
        period_timer_count <= wr_data;
      end else if (rollover) begin
        period_timer_count <= `CPW_RST_BYTE;
      end else if (tick) begin
        period_timer_count <= period_timer_count + 8'h01;
      end
    end
  end

  // Duty bytes and control
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      duty_write_byte <= `CPW_RST_BYTE;
      duty_shadow_byte <= `CPW_RST_BYTE;
      duty_lsb_latch <= 2'b00;
      unit_control_reg <= 6'h00;
      misc_reg <= 3'h0;
    end else begin
      if (wr_duty) begin
        duty_write_byte <= wr_data;
      end
      if (wr_ctrl) begin
        unit_control_reg <= wr_data[5:0];
      end
      if (wr_misc) begin
        misc_reg <= wr_data[2:0];
      end
      if (pwm_mode && rollover) begin
        duty_shadow_byte <= duty_next[9:2];
        duty_lsb_latch <= duty_next[1:0];
      end else if (wr_shadow && !pwm_mode) begin
        duty_shadow_byte <= wr_data;
      end
    end
  end

  // Unit output latch; port data latch lives outside this block
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_latch <= 1'b0;
    end else if (ctrl_off) begin
      wave_latch <= 1'b0;
    end else begin
      wave_latch <= next_wave;
    end
  end

  // Direction control belongs to the port logic; pin is driven as level
  assign wave_output_pin = wave_latch;
endmodule // cpw_pwm

// [tb/cpw_pwm_properties.sv]
`timescale 1ns/100ps
`include "cpw_defines.svh"

module cpw_pwm_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Write
  input wire logic [4:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Read
  input wire logic [4:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Pin
  input wire logic wave_output_pin
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ctrl_zero;
    wr_take ##0 (s_axi_awaddr == {1'b0, `CPW_ADDR_CTRL} &&
      s_axi_wdata[7:0] == 8'h00);
  endsequence
  sequence ctrl_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == {1'b0, `CPW_ADDR_CTRL};
  endsequence

  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
  write_answer_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("no write response");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("no read data");
  busy_refuse_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("ready while busy");
  unmapped_error_a: assert property (wr_take ##0
    (s_axi_awaddr > `CPW_ADDR_COUNT) |-> ##[1:2]
    (s_axi_bvalid && s_axi_bresp == `CPW_RESP_SLVERR))
    else $error("unmapped write accepted");
  rdata_upper_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits");
  ctrl_top_a: assert property (
    ctrl_read |=> s_axi_rdata[7:6] == 2'b00) else $error("ctrl top bits");
  ctrl_clear_a: assert property (
    ctrl_zero |-> ##3 (!wave_output_pin) [*4]) else $error("pin not low");
endmodule // cpw_pwm_properties

bind cpw_pwm cpw_pwm_properties u_cpw_pwm_properties (.aclk, .aresetn,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .wave_output_pin);

// [tb/cpw_load.sv]
`timescale 1ns/100ps

module cpw_load (
  // Clock
  input wire logic aclk,
  // Pin
  input wire logic wave_output_pin,
  // Lengths in cycles
  output logic [15:0] hi_len,
  output logic [15:0] per_len
);
  logic prev = 1'b0;
  logic [15:0] since = 16'h0;
  logic [15:0] hi_q = 16'h0;
  logic [15:0] per_q = 16'h0;
  assign hi_len = hi_q;
  assign per_len = per_q;
  // Load sees the pin only as an output, direction already set
  always @(posedge aclk) begin
    prev <= wave_output_pin;
    if (wave_output_pin === 1'b1 && prev === 1'b0) begin
      per_q <= since;
      since <= 16'h1;
    end else begin
      since <= since + 16'h1;
    end
    if (wave_output_pin === 1'b0 && prev === 1'b1) begin
      hi_q <= since;
    end
  end
endmodule // cpw_load

// [tb/ccp_pwm_period_duty_unit_tb.sv]
`timescale 1ns/100ps
`include "cpw_defines.svh"

module ccp_pwm_period_duty_unit_tb;
  import cpw_pkg::*;
  logic aclk, aresetn, wave_output_pin;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp, lsb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [15:0] hi_len, per_len, cnt;
  logic [7:0] lim, duty;
  int err_total, num_checks, pre;
  integer seed;

  cpw_pwm u_cpw_pwm (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .wave_output_pin);
  cpw_load u_cpw_load (.aclk, .wave_output_pin, .hi_len, .per_len);

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end
  // Whole run is a few thousand cycles
  initial begin
    #100000;
    err_total++;
    end_sim;
  end

  function automatic logic [15:0] exp_hi(input logic [7:0] d,
                                         input logic [1:0] b);
    return 16'(d * pre + b * (pre / 4));
  endfunction
  function automatic logic [15:0] exp_per(input logic [7:0] l);
    return 16'((l + 1) * pre);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axw(input logic [4:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Stop and clear the timer first so a shorter limit cannot strand it
  task automatic run_cfg(input logic [7:0] l, input logic [7:0] d,
                         input logic [1:0] b);
    axw(`CPW_ADDR_MISC, 8'h00);
    axw(`CPW_ADDR_COUNT, 8'h00);
    axw({1'b0, `CPW_ADDR_PERIOD}, l);
    axw({1'b0, `CPW_ADDR_DUTY_WR}, d);
    axw({1'b0, `CPW_ADDR_CTRL}, {2'b00, b, 4'hc});
    axw(`CPW_ADDR_MISC, {6'h1, pre == 16 ? CPW_PRE_16 :
                        pre == 4 ? CPW_PRE_4 : CPW_PRE_1});
  endtask
  task automatic cnt_hi(input int w, input int n);
    repeat (w) @(posedge aclk);
    cnt = 16'h0;
    repeat (n) begin
      @(posedge aclk);
      if (wave_output_pin === 1'b1) cnt++;
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  initial begin
    seed = 58;
    pre = 1;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'h1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    axr({1'b0, `CPW_ADDR_PERIOD});
    chk(rd, {24'h0, `CPW_RST_PERIOD});
    chk({30'h0, rsp}, {30'h0, `CPW_RESP_OKAY});
    axr(5'h1c);
    chk({30'h0, rsp}, {30'h0, `CPW_RESP_SLVERR});
    chk(rd, 32'h0);
    for (int a = 4; a <= 20; a += 4) begin
      axr(5'(a));
      chk(rd, {24'h0, `CPW_RST_BYTE});
    end
    axw({1'b0, `CPW_ADDR_CTRL}, 8'hff);
    chk({30'h0, rsp}, {30'h0, `CPW_RESP_OKAY});
    axr({1'b0, `CPW_ADDR_CTRL});
    chk(rd, {24'h0, `CPW_CTRL_MASK});
    axw(5'h18, 8'h5a);
    chk({30'h0, rsp}, {30'h0, `CPW_RESP_SLVERR});
    $display("test registers done");
    // First pass uses duty equal to the limit, the tightest match
    for (int i = 0; i < 8; i++) begin
      pre = (i < 3) ? 1 : (i < 6) ? 4 : 16;
      lim = 8'h8 + 8'($unsigned($random(seed)) % 24);
      duty = (i == 0) ? lim : 8'h1 + 8'($unsigned($random(seed)) % lim);
      lsb = (i < 3) ? 2'b00 : 2'($random(seed));
      run_cfg(lim, duty, lsb);
      repeat (3 * (lim + 1) * pre + 8) @(posedge aclk);
      chk({16'h0, hi_len}, {16'h0, exp_hi(duty, lsb)});
      chk({16'h0, per_len}, {16'h0, exp_per(lim)});
      axw(`CPW_ADDR_MISC, 8'h00);
      axw({1'b0, `CPW_ADDR_DUTY_WR}, ~duty);
      axw({1'b0, `CPW_ADDR_SHADOW}, 8'h3c);
      axr({1'b0, `CPW_ADDR_SHADOW});
      chk(rd, {24'h0, duty});
      $display("test pwm %0d done", i);
    end
    pre = 1;
    run_cfg(8'h0a, 8'h14, 2'b00);
    cnt_hi(16, 22);
    chk({16'h0, cnt}, 32'h16);
    run_cfg(8'h0a, 8'h00, 2'b00);
    cnt_hi(24, 22);
    chk({16'h0, cnt}, 32'h0);
    run_cfg(8'h0a, 8'h05, 2'b00);
    repeat (24) @(posedge aclk);
    axw({1'b0, `CPW_ADDR_CTRL}, 8'h00);
    cnt_hi(2, 22);
    chk({16'h0, cnt}, 32'h0);
    axw({1'b0, `CPW_ADDR_SHADOW}, 8'h3c);
    axr({1'b0, `CPW_ADDR_SHADOW});
    chk(rd, 32'h3c);
    $display("test edges done");
    end_sim;
  end
endmodule // ccp_pwm_period_duty_unit_tb
